/* acr_regs.sv */
// Channel 0 calibration and configuration registers behind a Wishbone slave
`timescale 1ns/1ps
module acr_regs
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Raw channel 0 conversions
  input  wire logic        sampleValid,
  input  wire logic [23:0] sampleRaw,
  // Settings driven into the channel 0 front end and filter
  output logic [1:0]       chan0InputSelect,
  output logic [9:0]       chan0PhaseDelay,
  output logic             dcRemovalActive,
  output logic [3:0]       dcRemovalSetting,
  // Corrected result and current detect
  output logic             resultValid,
  output logic [23:0]      result,
  output logic             detectHit
);

  // ---------------------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------------------
  logic        detectModeOn;
  logic [15:0] detectThresholdUpper;
  logic [7:0]  detectThresholdLower;
  logic [3:0]  dcSetting;
  logic [9:0]  phaseDelay;
  logic        chan0DcRemovalOff;
  logic [1:0]  inputSelect;
  logic [15:0] chan0OffsetUpper;
  logic [7:0]  chan0OffsetLower;
  logic [15:0] chan0GainUpper;
  logic [7:0]  chan0GainLower;
  logic        lastHit;

  logic        next_detectModeOn;
  logic [15:0] next_detectThresholdUpper;
  logic [7:0]  next_detectThresholdLower;
  logic [3:0]  next_dcSetting;
  logic [9:0]  next_phaseDelay;
  logic        next_chan0DcRemovalOff;
  logic [1:0]  next_inputSelect;
  logic [15:0] next_chan0OffsetUpper;
  logic [7:0]  next_chan0OffsetLower;
  logic [15:0] next_chan0GainUpper;
  logic [7:0]  next_chan0GainLower;
  logic        next_lastHit;

  // ---------------------------------------------------------------------------
  // Bus handshake
  // ---------------------------------------------------------------------------
  logic        busReq;
  logic        busWrite;
  logic [5:0]  regIndex;
  logic [15:0] wrWord;
  logic [15:0] rdWord;
  logic [31:0] next_wb_dat_o;
  logic        next_wb_ack_o;
  logic [23:0] detectThreshold;
  logic [23:0] offsetCal;
  logic [23:0] gainCal;
  logic [23:0] calResult;
  logic        calValid;

  assign busReq          = wb_cyc_i && wb_stb_i;
  assign regIndex        = wb_adr_i[7:2];
  assign detectThreshold = {detectThresholdUpper, detectThresholdLower};
  assign offsetCal       = {chan0OffsetUpper, chan0OffsetLower};
  assign gainCal         = {chan0GainUpper, chan0GainLower};

  // A write only lands on the edge where the master sees ack; a request held
  // past ack gets a fresh ack and lands again every second cycle.
  assign busWrite = busReq && wb_we_i && wb_ack_o;

  // Byte lanes 0 and 1 carry the 16-bit register; lanes 2 and 3 are ignored
  function automatic logic [15:0] merge_lanes(input logic [15:0] oldWord,
                                              input logic [15:0] newWord,
                                              input logic [1:0]  lanes);
    logic [15:0] merged;
    merged = oldWord;
    if (lanes[0])
      merged[7:0] = newWord[7:0];
    if (lanes[1])
      merged[15:8] = newWord[15:8];
    return merged;
  endfunction : merge_lanes

  // ---------------------------------------------------------------------------
  // Read multiplexer
  // ---------------------------------------------------------------------------
  always_comb
  begin
    rdWord = 16'h0000;
    unique case (regIndex)
      acr_pkg::IDX_DETECT_CONFIG:
        rdWord[acr_pkg::POS_DETECT_ON] = detectModeOn;
      acr_pkg::IDX_THRESHOLD_HIGH:
        rdWord = detectThresholdUpper;
      acr_pkg::IDX_THRESHOLD_LOW_DC:
        rdWord = {detectThresholdLower, 4'h0, dcSetting};
      acr_pkg::IDX_CHAN0_CONFIG:
        rdWord = {phaseDelay, 3'h0, chan0DcRemovalOff, inputSelect};
      acr_pkg::IDX_OFFSET_CAL_HIGH:
        rdWord = chan0OffsetUpper;
      acr_pkg::IDX_OFFSET_CAL_LOW:
        rdWord = {chan0OffsetLower, 8'h00};
      acr_pkg::IDX_GAIN_CAL_HIGH:
        rdWord = chan0GainUpper;
      acr_pkg::IDX_GAIN_CAL_LOW:
        rdWord = {chan0GainLower, 8'h00};
      default:
        rdWord = 16'h0000;
    endcase
  end

  always_comb
  begin
    next_wb_ack_o = busReq && !wb_ack_o;
    next_wb_dat_o = 32'h00000000;
    if (busReq && !wb_ack_o && !wb_we_i)
    begin
      if (regIndex == acr_pkg::IDX_RESULT_STATUS)
        next_wb_dat_o = {7'h00, lastHit, result};
      else
        next_wb_dat_o = {16'h0000, rdWord};
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= next_wb_ack_o;
      wb_dat_o <= next_wb_dat_o;
    end
  end

  // ---------------------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------------------
  always_comb
  begin
    next_detectModeOn         = detectModeOn;
    next_detectThresholdUpper = detectThresholdUpper;
    next_detectThresholdLower = detectThresholdLower;
    next_dcSetting            = dcSetting;
    next_phaseDelay           = phaseDelay;
    next_chan0DcRemovalOff    = chan0DcRemovalOff;
    next_inputSelect          = inputSelect;
    next_chan0OffsetUpper     = chan0OffsetUpper;
    next_chan0OffsetLower     = chan0OffsetLower;
    next_chan0GainUpper       = chan0GainUpper;
    next_chan0GainLower       = chan0GainLower;
    wrWord = merge_lanes(rdWord, wb_dat_i[15:0], wb_sel_i[1:0]);
    if (busWrite)
    begin
      unique case (regIndex)
        acr_pkg::IDX_DETECT_CONFIG:
          next_detectModeOn = wrWord[acr_pkg::POS_DETECT_ON];
        acr_pkg::IDX_THRESHOLD_HIGH:
          next_detectThresholdUpper = wrWord;
        acr_pkg::IDX_THRESHOLD_LOW_DC:
        begin
          next_detectThresholdLower = wrWord[15:acr_pkg::POS_LOWER_BYTE];
          next_dcSetting = wrWord[acr_pkg::POS_DC_SETTING +: 4];
        end
        acr_pkg::IDX_CHAN0_CONFIG:
        begin
          next_phaseDelay        = wrWord[acr_pkg::POS_PHASE_DELAY +: 10];
          next_chan0DcRemovalOff = wrWord[acr_pkg::POS_DC_OFF];
          next_inputSelect       = wrWord[acr_pkg::POS_INPUT_SELECT +: 2];
        end
        acr_pkg::IDX_OFFSET_CAL_HIGH:
          next_chan0OffsetUpper = wrWord;
        acr_pkg::IDX_OFFSET_CAL_LOW:
          next_chan0OffsetLower = wrWord[15:acr_pkg::POS_LOWER_BYTE];
        acr_pkg::IDX_GAIN_CAL_HIGH:
          next_chan0GainUpper = wrWord;
        acr_pkg::IDX_GAIN_CAL_LOW:
          next_chan0GainLower = wrWord[15:acr_pkg::POS_LOWER_BYTE];
        default:
          next_detectModeOn = detectModeOn;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      detectModeOn         <= acr_pkg::RST_DETECT_ON;
      detectThresholdUpper <= acr_pkg::RST_THRESHOLD_UPPER;
      detectThresholdLower <= acr_pkg::RST_THRESHOLD_LOWER;
      dcSetting            <= acr_pkg::RST_DC_SETTING;
      phaseDelay           <= acr_pkg::RST_PHASE_DELAY;
      chan0DcRemovalOff    <= acr_pkg::RST_DC_OFF;
      inputSelect          <= acr_pkg::RST_INPUT_SELECT;
      chan0OffsetUpper     <= acr_pkg::RST_OFFSET_UPPER;
      chan0OffsetLower     <= acr_pkg::RST_OFFSET_LOWER;
      chan0GainUpper       <= acr_pkg::RST_GAIN_UPPER;
      chan0GainLower       <= acr_pkg::RST_GAIN_LOWER;
    end
    else
    begin
      detectModeOn         <= next_detectModeOn;
      detectThresholdUpper <= next_detectThresholdUpper;
      detectThresholdLower <= next_detectThresholdLower;
      dcSetting            <= next_dcSetting;
      phaseDelay           <= next_phaseDelay;
      chan0DcRemovalOff    <= next_chan0DcRemovalOff;
      inputSelect          <= next_inputSelect;
      chan0OffsetUpper     <= next_chan0OffsetUpper;
      chan0OffsetLower     <= next_chan0OffsetLower;
      chan0GainUpper       <= next_chan0GainUpper;
      chan0GainLower       <= next_chan0GainLower;
    end
  end

  // ---------------------------------------------------------------------------
  // Settings to the front end
  // ---------------------------------------------------------------------------
  // Registered so the analog controls never see a decode glitch
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      chan0InputSelect <= acr_pkg::RST_INPUT_SELECT;
      chan0PhaseDelay  <= acr_pkg::RST_PHASE_DELAY;
      dcRemovalActive  <= !acr_pkg::RST_DC_OFF;
      dcRemovalSetting <= acr_pkg::RST_DC_SETTING;
    end
    else
    begin
      chan0InputSelect <= inputSelect;
      chan0PhaseDelay  <= phaseDelay;
      dcRemovalActive  <= !chan0DcRemovalOff;
      dcRemovalSetting <= chan0DcRemovalOff ? 4'h0 : dcSetting;
    end
  end

  // ---------------------------------------------------------------------------
  // Calibration and current detect
  // ---------------------------------------------------------------------------
  acr_cal_path u_cal_path
  (
    .clk         (clk),
    .reset       (reset),
    .sampleValid (sampleValid),
    .sampleRaw   (sampleRaw),
    .offsetCal   (offsetCal),
    .gainCal     (gainCal),
    .resultValid (calValid),
    .result      (calResult)
  );

  assign resultValid = calValid;
  assign result      = calResult;

  // Hit holds the last compare until the next result or until detect is off
  always_comb
  begin
    next_lastHit = lastHit;
    if (!detectModeOn)
      next_lastHit = 1'b0;
    else if (calValid)
      next_lastHit = $signed(calResult) > $signed(detectThreshold);
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      lastHit   <= 1'b0;
      detectHit <= 1'b0;
    end
    else
    begin
      lastHit   <= next_lastHit;
      detectHit <= next_lastHit;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  sequence s_write_to(logic [5:0] idx);
    busReq && wb_we_i && wb_ack_o && regIndex == idx && wb_sel_i[1:0] == 2'b11;
  endsequence

  sequence s_read_of(logic [5:0] idx);
    busReq && !wb_we_i && !wb_ack_o && regIndex == idx;
  endsequence

  a_ack_single: assert property (@(posedge clk) disable iff (reset)
    (busReq && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle after request");

  a_thr_upper_write: assert property (@(posedge clk) disable iff (reset)
    s_write_to(acr_pkg::IDX_THRESHOLD_HIGH) |=> detectThresholdUpper == $past(wb_dat_i[15:0]))
    else $error("threshold upper write lost");

  a_thr_lower_write: assert property (@(posedge clk) disable iff (reset)
    s_write_to(acr_pkg::IDX_THRESHOLD_LOW_DC) |=> detectThresholdLower == $past(wb_dat_i[15:8]))
    else $error("threshold lower write lost");

  a_dc_field_read: assert property (@(posedge clk) disable iff (reset)
    s_read_of(acr_pkg::IDX_THRESHOLD_LOW_DC) |=> wb_ack_o && wb_dat_o[7:4] == 4'h0
      && wb_dat_o[3:0] == $past(dcSetting))
    else $error("dc setting read wrong");

  a_phase_write_out: assert property (@(posedge clk) disable iff (reset)
    s_write_to(acr_pkg::IDX_CHAN0_CONFIG) |=> ##1 chan0PhaseDelay == $past(wb_dat_i[15:6], 2))
    else $error("phase delay not driven out");

  a_dc_bypass: assert property (@(posedge clk) disable iff (reset)
    chan0DcRemovalOff [*2] |-> !dcRemovalActive && dcRemovalSetting == 4'h0)
    else $error("dc removal not bypassed");

  a_insel_out: assert property (@(posedge clk) disable iff (reset)
    s_write_to(acr_pkg::IDX_CHAN0_CONFIG) |=> ##1 chan0InputSelect == $past(wb_dat_i[1:0], 2))
    else $error("input select not driven out");

  a_ocal_low_read: assert property (@(posedge clk) disable iff (reset)
    s_read_of(acr_pkg::IDX_OFFSET_CAL_LOW) |=> wb_dat_o[7:0] == 8'h00
      && wb_dat_o[15:8] == $past(chan0OffsetLower))
    else $error("offset low byte read wrong");

  a_ocal_upper_write: assert property (@(posedge clk) disable iff (reset)
    s_write_to(acr_pkg::IDX_OFFSET_CAL_HIGH) |=> chan0OffsetUpper == $past(wb_dat_i[15:0]))
    else $error("offset upper write lost");

  a_gain_reset: assert property (@(posedge clk)
    reset |=> chan0GainUpper == acr_pkg::RST_GAIN_UPPER)
    else $error("gain upper reset value wrong");

  a_detect_gate: assert property (@(posedge clk) disable iff (reset)
    !detectModeOn |=> !detectHit)
    else $error("detect hit while detect mode off");

  a_detect_compare: assert property (@(posedge clk) disable iff (reset)
    (detectModeOn && calValid && $signed(calResult) > $signed(detectThreshold)) |=> detectHit)
    else $error("detect hit missing above threshold");

endmodule : acr_regs

/* acr_pkg.sv */
// Constants for the channel 0 calibration and configuration register bank
package acr_pkg;

  // ---------------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------------------
  localparam logic [5:0] IDX_DETECT_CONFIG     = 6'h06;
  localparam logic [5:0] IDX_THRESHOLD_HIGH    = 6'h07;
  localparam logic [5:0] IDX_THRESHOLD_LOW_DC  = 6'h08;
  localparam logic [5:0] IDX_CHAN0_CONFIG      = 6'h09;
  localparam logic [5:0] IDX_OFFSET_CAL_HIGH   = 6'h0A;
  localparam logic [5:0] IDX_OFFSET_CAL_LOW    = 6'h0B;
  localparam logic [5:0] IDX_GAIN_CAL_HIGH     = 6'h0C;
  localparam logic [5:0] IDX_GAIN_CAL_LOW      = 6'h0D;
  localparam logic [5:0] IDX_RESULT_STATUS     = 6'h10;

  // ---------------------------------------------------------------------------
  // Bus widths
  // ---------------------------------------------------------------------------
  localparam int ADR_W  = 8;
  localparam int DAT_W  = 32;
  localparam int SAMP_W = 24;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [15:0] RST_THRESHOLD_UPPER = 16'h0000;
  localparam logic [7:0]  RST_THRESHOLD_LOWER = 8'h00;
  localparam logic [3:0]  RST_DC_SETTING      = 4'h0;
  localparam logic [9:0]  RST_PHASE_DELAY     = 10'h000;
  localparam logic        RST_DC_OFF          = 1'b0;
  localparam logic [1:0]  RST_INPUT_SELECT    = 2'h0;
  localparam logic [15:0] RST_OFFSET_UPPER    = 16'h0000;
  localparam logic [7:0]  RST_OFFSET_LOWER    = 8'h00;
  localparam logic [15:0] RST_GAIN_UPPER      = 16'h8000;
  localparam logic [7:0]  RST_GAIN_LOWER      = 8'h00;
  localparam logic        RST_DETECT_ON       = 1'b0;

  // ---------------------------------------------------------------------------
  // Field positions inside the 16-bit registers and the 32-bit status word
  // ---------------------------------------------------------------------------
  localparam int POS_LOWER_BYTE   = 8;
  localparam int POS_DC_SETTING   = 0;
  localparam int POS_PHASE_DELAY  = 6;
  localparam int POS_DC_OFF       = 2;
  localparam int POS_INPUT_SELECT = 0;
  localparam int POS_DETECT_ON    = 0;
  localparam int POS_DETECT_HIT   = 24;

  // ---------------------------------------------------------------------------
  // Input select codes
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    INSEL_PINS     = 2'b00,
    INSEL_SHORTED  = 2'b01,
    INSEL_TEST_POS = 2'b10,
    INSEL_TEST_NEG = 2'b11
  } acr_insel_t;

  // ---------------------------------------------------------------------------
  // Calibration arithmetic
  // ---------------------------------------------------------------------------
  localparam int          GAIN_FRAC_BITS = 23;
  localparam logic [23:0] GAIN_UNITY     = 24'h800000;
  localparam logic [23:0] SAMPLE_MAX     = 24'h7FFFFF;
  localparam logic [23:0] SAMPLE_MIN     = 24'h800000;

endpackage : acr_pkg

/* acr_cal_path.sv */
// Offset and gain correction of channel 0 conversion results
`timescale 1ns/1ps
module acr_cal_path
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Raw conversion
  input  wire logic        sampleValid,
  input  wire logic [23:0] sampleRaw,
  // Calibration words
  input  wire logic [23:0] offsetCal,
  input  wire logic [23:0] gainCal,
  // Corrected conversion
  output logic             resultValid,
  output logic [23:0]      result
);

  logic signed [24:0] diff;
  logic signed [49:0] product;
  logic signed [49:0] scaled;
  logic [23:0]        next_result;
  logic               next_resultValid;

  // ---------------------------------------------------------------------------
  // Arithmetic
  // ---------------------------------------------------------------------------
  // Gain is unsigned 0.0 up to just under 2.0, unity at the top bit
  always_comb
  begin
    diff    = $signed({sampleRaw[23], sampleRaw}) - $signed({offsetCal[23], offsetCal});
    product = diff * $signed({1'b0, gainCal});
    scaled  = product >>> acr_pkg::GAIN_FRAC_BITS;
    next_resultValid = sampleValid;
    next_result      = result;
    if (sampleValid)
    begin
      // Saturate rather than wrap, so an overload never flips sign
      if (scaled > $signed({26'h0, acr_pkg::SAMPLE_MAX}))
        next_result = acr_pkg::SAMPLE_MAX;
      else if (scaled < $signed({{26{1'b1}}, acr_pkg::SAMPLE_MIN}))
        next_result = acr_pkg::SAMPLE_MIN;
      else
        next_result = scaled[23:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      resultValid <= 1'b0;
      result      <= 24'h000000;
    end
    else
    begin
      resultValid <= next_resultValid;
      result      <= next_result;
    end
  end

  a_unity_pass: assert property (@(posedge clk) disable iff (reset)
    (sampleValid && gainCal == acr_pkg::GAIN_UNITY && offsetCal == 24'h000000)
      |=> (resultValid && result == $past(sampleRaw)))
    else $error("unity gain, zero offset did not pass sample through");

endmodule : acr_cal_path

/* acr_regs_tb.sv */
// Self-checking testbench for the channel 0 calibration register bank
`timescale 1ns/1ps
module acr_regs_tb;
  typedef struct packed {logic [5:0] idx; logic [15:0] rst, wr, rd;} acr_row_t;
  logic        clk, reset, cyc, stb, we, ack, sampleValid;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] datI, datO, rdData;
  logic [23:0] sampleRaw, result;
  logic [1:0]  chan0InputSelect;
  logic [9:0]  chan0PhaseDelay;
  logic        dcRemovalActive, resultValid, detectHit;
  logic [3:0]  dcRemovalSetting;
  int          errCount, totalChecks;
  acr_row_t    rows [6] = '{'{6'h07, 16'h0000, 16'hFFFF, 16'hFFFF},
                            '{6'h08, 16'h0000, 16'hFFFF, 16'hFF0F},
                            '{6'h09, 16'h0000, 16'hFFFF, 16'hFFC7},
                            '{6'h0A, 16'h0000, 16'h1234, 16'h1234},
                            '{6'h0B, 16'h0000, 16'hFFFF, 16'hFF00},
                            '{6'h0C, 16'h8000, 16'h4000, 16'h4000}};

  acr_regs DUT (.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack),
    .sampleValid(sampleValid), .sampleRaw(sampleRaw), .chan0InputSelect(chan0InputSelect),
    .chan0PhaseDelay(chan0PhaseDelay), .dcRemovalActive(dcRemovalActive),
    .dcRemovalSetting(dcRemovalSetting), .resultValid(resultValid), .result(result),
    .detectHit(detectHit));

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp)
    begin
      errCount++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // The master waits for ack with no assumed latency; a missing ack is a mismatch
  task automatic wbCycle(input logic [5:0] idx, input logic wr, input logic [15:0] d,
                         input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= {idx, 2'b00};
    sel <= be;
    datI <= {16'h0000, d};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    rdData = datO;
    chk(32'(ack), 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wbCycle

  // Settings outputs follow one edge after the write lands
  task automatic wbWrite(input logic [5:0] idx, input logic [15:0] d, input logic [3:0] be);
    wbCycle(idx, 1'b1, d, be);
    @(posedge clk);
    #1;
  endtask : wbWrite

  task automatic wbRead(input logic [5:0] idx, input logic [15:0] exp);
    wbCycle(idx, 1'b0, 16'h0000, 4'hF);
    chk(rdData, {16'h0000, exp});
  endtask : wbRead

  task automatic sample(input logic [23:0] raw, input logic [23:0] exp);
    @(posedge clk);
    sampleValid <= 1'b1;
    sampleRaw <= raw;
    @(posedge clk);
    sampleValid <= 1'b0;
    sampleRaw <= ~raw;
    #1;
    chk(32'(resultValid), 32'h1);
    chk(32'(result), 32'(exp));
    @(posedge clk);
    #1;
  endtask : sample

  task automatic endOfTest;
    if (errCount == 0 && totalChecks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : endOfTest

  // ---------------------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ---------------------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial
  begin
    #(40 * 4000);
    errCount++;
    endOfTest();
  end

  initial
  begin
    {cyc, stb, we, sampleValid, adr, sel, datI, sampleRaw} = '0;
    errCount = 0;
    totalChecks = 0;
    reset = 1'b1;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    foreach (rows[i]) wbRead(rows[i].idx, rows[i].rst);
    foreach (rows[i])
    begin
      wbWrite(rows[i].idx, rows[i].wr, 4'hF);
      wbRead(rows[i].idx, rows[i].rd);
    end
    wbWrite(6'h08, 16'h0005, 4'hF);
    for (int m = 0; m < 4; m++)
    begin
      wbWrite(6'h09, {10'h2A5, 4'h0, 2'(m)}, 4'hF);
      chk(32'(chan0InputSelect), 32'(m));
      chk(32'(chan0PhaseDelay), 32'h2A5);
      chk(32'({dcRemovalActive, dcRemovalSetting}), 32'h15);
    end
    wbWrite(6'h09, 16'h0004, 4'hF);
    chk(32'({dcRemovalActive, dcRemovalSetting}), 32'h0);
    // Byte lanes and an unmapped index
    wbWrite(6'h0A, 16'hABCD, 4'h2);
    wbRead(6'h0A, 16'hAB34);
    wbWrite(6'h3F, 16'hFFFF, 4'hF);
    wbRead(6'h3F, 16'h0000);
    // Calibration arithmetic
    wbWrite(6'h0A, 16'h0001, 4'hF);
    wbWrite(6'h0B, 16'h0000, 4'hF);
    wbWrite(6'h0C, 16'h8000, 4'hF);
    sample(24'h000300, 24'h000200);
    wbWrite(6'h0C, 16'h4000, 4'hF);
    sample(24'h000500, 24'h000200);
    wbWrite(6'h0A, 16'h0000, 4'hF);
    wbWrite(6'h0C, 16'hFFFF, 4'hF);
    wbWrite(6'h0D, 16'hFF00, 4'hF);
    wbRead(6'h0D, 16'hFF00);
    sample(24'h500000, 24'h7FFFFF);
    sample(24'hA00000, 24'h800000);
    wbWrite(6'h0C, 16'h8000, 4'hF);
    wbWrite(6'h0D, 16'h0000, 4'hF);
    wbWrite(6'h0B, 16'h0100, 4'hF);
    sample(24'h000010, 24'h00000F);
    // Current detect against a threshold with a nonzero low byte
    wbWrite(6'h07, 16'h0000, 4'hF);
    wbWrite(6'h08, 16'h8000, 4'hF);
    wbWrite(6'h06, 16'h0001, 4'hF);
    wbRead(6'h06, 16'h0001);
    sample(24'h000082, 24'h000081);
    chk(32'(detectHit), 32'h1);
    sample(24'h000081, 24'h000080);
    chk(32'(detectHit), 32'h0);
    wbWrite(6'h07, 16'hFFFF, 4'hF);
    wbWrite(6'h08, 16'hFF00, 4'hF);
    sample(24'h000001, 24'h000000);
    chk(32'(detectHit), 32'h1);
    // Status word carries the hit flag above the corrected result
    wbCycle(6'h10, 1'b0, 16'h0000, 4'hF);
    chk(rdData, 32'h01000000);
    wbWrite(6'h06, 16'h0000, 4'hF);
    chk(32'(detectHit), 32'h0);
    // Second reset in mid-run
    @(posedge clk);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    wbRead(6'h0C, 16'h8000);
    wbRead(6'h07, 16'h0000);
    wbRead(6'h09, 16'h0000);
    chk(32'(result), 32'h0);
    sample(24'h123456, 24'h123456);
    endOfTest();
  end
endmodule : acr_regs_tb
